/* File: rtl/nvmwc_regs.svh */
`ifndef NVMWC_REGS_SVH
`define NVMWC_REGS_SVH

// special function register addresses and aux reset value
`define NVMWC_CMD_ADDR      8'hC9
`define NVMWC_AUX_CONTROL_TWO_ADDR     8'hF7
`define NVMWC_AUX_CONTROL_TWO_RESET    8'h06

// command codes
`define NVMWC_CODE_FLASH1   8'h47
`define NVMWC_CODE_FLASH2   8'h74
`define NVMWC_CODE_INFO     8'hA1
`define NVMWC_CODE_EE       8'hE2

// command and aux register bit positions
`define NVMWC_BIT_FLASH_WE  7
`define NVMWC_BIT_TIMEOUT   6
`define NVMWC_BIT_EE_WE     5
`define NVMWC_BIT_INFO_WE   4
`define NVMWC_WDS_LSB       1

// data space windows
`define NVMWC_EE_FIRST      16'hEE00
`define NVMWC_EE_LAST       16'hEEFE
`define NVMWC_INFO_FIRST    16'hE500
`define NVMWC_INFO_LAST     16'hE53F
`define NVMWC_INFO_BOOT     16'hE530
`define NVMWC_FLASH_LAST    16'h3FFE

// timing, clock 125 MHz
`define NVMWC_CLK_KHZ       125000
`define NVMWC_EE_READ_NS    300
`define NVMWC_EE_READ_CYC   ((`NVMWC_EE_READ_NS * 125 + 999) / 1000)
`define NVMWC_TICK_CYC      125
`define NVMWC_WD1_US        3000
`define NVMWC_WD2_US        6000
`define NVMWC_WD3_US        25000
`define NVMWC_INFO_PROG_US  600
`define NVMWC_EE_PROG_US    1000
`define NVMWC_FLASH_PROG_US 1000

`endif

/* File: rtl/nvmwc_pkg.sv */
package nvmwc_pkg;
	typedef enum logic [1:0] {
		NVMWC_IDLE = 2'b00,
		NVMWC_READ = 2'b01,
		NVMWC_PROG = 2'b11,
		NVMWC_DONE = 2'b10
	} nvmwc_state_t;

	typedef enum logic [1:0] {
		NVMWC_TGT_NONE  = 2'b00,
		NVMWC_TGT_EE    = 2'b01,
		NVMWC_TGT_INFO  = 2'b10,
		NVMWC_TGT_FLASH = 2'b11
	} nvmwc_target_t;
endpackage : nvmwc_pkg

/* File: rtl/nvmwc_mem.sv */
`timescale 1ns/1ps
// byte array with registered read data
module nvmwc_mem (
	input  wire logic       i_clock,
	input  wire logic       i_we,
	input  wire logic [6:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata
);
	logic [7:0] mem [0:127];

	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end
endmodule : nvmwc_mem

/* File: rtl/nvmwc_tick.sv */
`timescale 1ns/1ps
`include "nvmwc_regs.svh"
// one-cycle pulse every microsecond
module nvmwc_tick (
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	output logic      o_tick
);
	logic [6:0] cnt_r;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r  <= 7'h00;
			o_tick <= 1'b0;
		end else if (cnt_r == 7'(`NVMWC_TICK_CYC - 1)) begin
			cnt_r  <= 7'h00;
			o_tick <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 7'h01;
			o_tick <= 1'b0;
		end
	end
endmodule : nvmwc_tick

/* File: rtl/nvmwc_top.sv */
// Behaviour
// RQ1 - EEPROM bytes on even EE00h..EEFEh only
// RQ2 - EEPROM store stalls CPU until programmed
// RQ3 - stall leaves peripherals running, interrupts pending
// RQ4 - EEPROM load returns byte in about 300ns
// RQ5 - 47h/74h set flash enable, else clear
// RQ6 - A1h sets info enable, else clear
// RQ7 - E2h sets EEPROM enable, else clear
// RQ8 - command readback bits 7..4, reset zero
// RQ9 - timeout set on expiry, cleared with enables
// RQ10 - watchdog select 00 off, 3/6/25 ms
// RQ11 - select field aux bits 2:1, reset 11
// RQ12 - info E500h..E53Fh, boot sector writable only
// RQ13 - info store stalls about 0.6 ms
// RQ14 - info loads add no wait cycles
// RQ15 - EEPROM completion waits on real finish
// RQ16 - software clears EEPROM enable after write
// RQ17 - software masks interrupts around writes
// RQ18 - software clears system watchdog per byte
// RQ19 - software reads back and compares bytes
// RQ20 - flash stores ignored unless flash enable set
// RQ21 - odd or disabled EEPROM stores ignored, no stall
`timescale 1ns/1ps
`include "nvmwc_regs.svh"
module nvmwc_top
	import nvmwc_pkg::*;
#(
	parameter int unsigned WD1_CYC = `NVMWC_WD1_US * 125,
	parameter int unsigned WD2_CYC = `NVMWC_WD2_US * 125,
	parameter int unsigned WD3_CYC = `NVMWC_WD3_US * 125,
	parameter int unsigned INFO_PROG_CYC = `NVMWC_INFO_PROG_US * 125,
	parameter int unsigned FLASH_PROG_CYC = `NVMWC_FLASH_PROG_US * 125
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	// special function register port
	input  wire logic        i_sfr_wr,
	input  wire logic        i_sfr_rd,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	output logic             o_sfr_hit,
	// external data load/store port
	input  wire logic        i_xd_wr,
	input  wire logic        i_xd_rd,
	input  wire logic [15:0] i_xd_addr,
	input  wire logic [7:0]  i_xd_wdata,
	output logic      [7:0]  o_xd_rdata,
	output logic             o_xd_hit,
	output logic             o_xd_ready,
	output logic             o_cpu_stall,
	// nonvolatile cell array handshake (external macro)
	output logic             o_ee_prog_start,
	output logic      [6:0]  o_ee_prog_addr,
	output logic      [7:0]  o_ee_prog_data,
	output logic             o_ee_prog_abort,
	input  wire logic        i_ee_prog_done,
	output logic             o_flash_prog_start,
	output logic      [15:0] o_flash_prog_addr,
	output logic      [7:0]  o_flash_prog_data,
	output logic             o_flash_two_byte,
	output logic             o_info_prog_start,
	output logic      [5:0]  o_info_prog_addr,
	output logic      [7:0]  o_info_prog_data,
	input  wire logic [7:0]  i_info_rdata
);

	// ==========================================================
	// reset release
	// ==========================================================
	logic rst_meta_r;
	logic rst_b_r;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_r <= 1'b0;
			rst_b_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_b_r    <= rst_meta_r;
		end
	end

	// done comes from the analog macro, another timing domain
	logic done_meta_r;
	logic done_sync_r;
	logic done_old_r;

	always_ff @(posedge i_clock or negedge rst_b_r) begin
		if (!rst_b_r) begin
			done_meta_r <= 1'b0;
			done_sync_r <= 1'b0;
			done_old_r  <= 1'b0;
		end else begin
			done_meta_r <= i_ee_prog_done;
			done_sync_r <= done_meta_r;
			done_old_r  <= done_sync_r;
		end
	end

	// ==========================================================
	// address decode
	// ==========================================================
	function automatic nvmwc_target_t decode(input logic [15:0] a);
		if (a >= `NVMWC_EE_FIRST && a <= `NVMWC_EE_LAST + 16'h0001) begin
			decode = NVMWC_TGT_EE;
		end else if (a >= `NVMWC_INFO_FIRST && a <= `NVMWC_INFO_LAST) begin
			decode = NVMWC_TGT_INFO;
		end else if (a <= `NVMWC_FLASH_LAST) begin
			decode = NVMWC_TGT_FLASH;
		end else begin
			decode = NVMWC_TGT_NONE;
		end
	endfunction : decode

	nvmwc_target_t tgt;
	assign tgt = decode(i_xd_addr);

	// ==========================================================
	// registers
	// ==========================================================
	logic       flash_we_r;
	logic       two_byte_r;
	logic       ee_we_r;
	logic       info_we_r;
	logic       timeout_r;
	logic [7:0] aux_control_two_r;
	logic       cmd_wr;
	logic       wd_expire;

	assign cmd_wr = i_sfr_wr && (i_sfr_addr == `NVMWC_CMD_ADDR);

	always_ff @(posedge i_clock or negedge rst_b_r) begin
		if (!rst_b_r) begin
			flash_we_r <= 1'b0;
			two_byte_r <= 1'b0;
			ee_we_r    <= 1'b0;
			info_we_r  <= 1'b0;
		end else if (cmd_wr) begin
			// RQ5 flash enable codes
			flash_we_r <= (i_sfr_wdata == `NVMWC_CODE_FLASH1) || (i_sfr_wdata == `NVMWC_CODE_FLASH2);
			two_byte_r <= (i_sfr_wdata == `NVMWC_CODE_FLASH2);
			// RQ6 info enable code
			info_we_r  <= (i_sfr_wdata == `NVMWC_CODE_INFO);
			// RQ7 EEPROM enable code
			ee_we_r    <= (i_sfr_wdata == `NVMWC_CODE_EE);
		end
	end

	// the command write always clears at least two enables, so the
	// flag clears on it; an expiry in that same cycle still sets it
	always_ff @(posedge i_clock or negedge rst_b_r) begin
		if (!rst_b_r) begin
			timeout_r <= 1'b0;
		// RQ9 set wins over clear
		end else if (wd_expire) begin
			timeout_r <= 1'b1;
		end else if (cmd_wr) begin
			timeout_r <= 1'b0;
		end
	end

	// RQ11 aux register, field reset 11
	always_ff @(posedge i_clock or negedge rst_b_r) begin
		if (!rst_b_r) begin
			aux_control_two_r <= `NVMWC_AUX_CONTROL_TWO_RESET;
		end else if (i_sfr_wr && i_sfr_addr == `NVMWC_AUX_CONTROL_TWO_ADDR) begin
			aux_control_two_r <= i_sfr_wdata;
		end
	end

	logic [1:0] wd_sel;
	assign wd_sel = aux_control_two_r[`NVMWC_WDS_LSB +: 2];

	// RQ8 readback layout
	always_comb begin
		o_sfr_hit   = i_sfr_rd && (i_sfr_addr == `NVMWC_CMD_ADDR || i_sfr_addr == `NVMWC_AUX_CONTROL_TWO_ADDR);
		o_sfr_rdata = 8'h00;
		if (i_sfr_addr == `NVMWC_CMD_ADDR) begin
			o_sfr_rdata[`NVMWC_BIT_FLASH_WE] = flash_we_r;
			o_sfr_rdata[`NVMWC_BIT_TIMEOUT]  = timeout_r;
			o_sfr_rdata[`NVMWC_BIT_EE_WE]    = ee_we_r;
			o_sfr_rdata[`NVMWC_BIT_INFO_WE]  = info_we_r;
		end else if (i_sfr_addr == `NVMWC_AUX_CONTROL_TWO_ADDR) begin
			o_sfr_rdata = aux_control_two_r;
		end
	end

	// ==========================================================
	// access sequencer
	// ==========================================================
	nvmwc_state_t  state_r;
	nvmwc_target_t busy_tgt_r;
	logic [21:0]   prog_cnt_r;
	logic [21:0]   wd_cnt_r;
	logic [21:0]   wd_limit;
	logic [5:0]    rd_cnt_r;
	logic          us_tick;
	logic          ee_go;
	logic          info_go;
	logic          flash_go;
	logic          ee_rd;
	logic          prog_finish;
	logic [7:0]    ee_rdata;

	nvmwc_tick u_tick (
		.i_clock (i_clock),
		.i_rst_b (rst_b_r),
		.o_tick  (us_tick)
	);

	// RQ1 even addresses only
	// RQ21 odd or disabled stores dropped
	assign ee_go = i_xd_wr && tgt == NVMWC_TGT_EE && !i_xd_addr[0] && ee_we_r;
	// RQ12 boot sector only with info enable
	assign info_go = i_xd_wr && tgt == NVMWC_TGT_INFO && i_xd_addr >= `NVMWC_INFO_BOOT && info_we_r;
	// RQ20 flash store gate
	assign flash_go = i_xd_wr && tgt == NVMWC_TGT_FLASH && flash_we_r;
	assign ee_rd = i_xd_rd && tgt == NVMWC_TGT_EE && !i_xd_addr[0];

	always_comb begin
		unique case (wd_sel)
			2'b00: wd_limit = 22'h0;
			2'b01: wd_limit = 22'(WD1_CYC);
			2'b10: wd_limit = 22'(WD2_CYC);
			2'b11: wd_limit = 22'(WD3_CYC);
		endcase
	end

	// RQ10 watchdog expiry ends the wait; only an EEPROM write gets an abort
	assign wd_expire = state_r == NVMWC_PROG && wd_sel != 2'b00 && wd_cnt_r >= wd_limit;

	always_comb begin
		unique case (busy_tgt_r)
			// RQ15 EEPROM finish from cell macro
			// only a fresh rise counts: done may still stand from the previous write
			NVMWC_TGT_EE:    prog_finish = done_sync_r && !done_old_r;
			// RQ13 info programming time
			NVMWC_TGT_INFO:  prog_finish = prog_cnt_r >= 22'(INFO_PROG_CYC);
			NVMWC_TGT_FLASH: prog_finish = prog_cnt_r >= 22'(FLASH_PROG_CYC);
			NVMWC_TGT_NONE:  prog_finish = 1'b1;
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_b_r) begin
		if (!rst_b_r) begin
			state_r    <= NVMWC_IDLE;
			busy_tgt_r <= NVMWC_TGT_NONE;
			prog_cnt_r <= 22'h0;
			wd_cnt_r   <= 22'h0;
			rd_cnt_r   <= 6'h00;
		end else begin
			unique case (state_r)
				NVMWC_IDLE: begin
					prog_cnt_r <= 22'h0;
					wd_cnt_r   <= 22'h0;
					rd_cnt_r   <= 6'h00;
					if (ee_go) begin
						busy_tgt_r <= NVMWC_TGT_EE;
						state_r    <= NVMWC_PROG;
					end else if (info_go) begin
						busy_tgt_r <= NVMWC_TGT_INFO;
						state_r    <= NVMWC_PROG;
					end else if (flash_go) begin
						busy_tgt_r <= NVMWC_TGT_FLASH;
						state_r    <= NVMWC_PROG;
					end else if (ee_rd) begin
						state_r <= NVMWC_READ;
					end
				end
				// RQ4 EEPROM read access time
				NVMWC_READ: begin
					rd_cnt_r <= rd_cnt_r + 6'h01;
					if (rd_cnt_r == 6'(`NVMWC_EE_READ_CYC - 2)) begin
						state_r <= NVMWC_DONE;
					end
				end
				NVMWC_PROG: begin
					prog_cnt_r <= prog_cnt_r + 22'h1;
					wd_cnt_r   <= wd_cnt_r + 22'h1;
					if (prog_finish || wd_expire) begin
						state_r <= NVMWC_DONE;
					end
				end
				NVMWC_DONE: begin
					busy_tgt_r <= NVMWC_TGT_NONE;
					state_r    <= NVMWC_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// CPU handshake
	// ==========================================================
	// RQ2 stall across programming
	// RQ3 only the CPU waits; interrupts stay pending upstream
	assign o_cpu_stall = state_r == NVMWC_PROG || state_r == NVMWC_READ || (state_r == NVMWC_IDLE && (ee_go
		|| info_go || flash_go || ee_rd));
	// RQ14 info loads finish at once
	assign o_xd_ready = state_r == NVMWC_DONE || (state_r == NVMWC_IDLE && !(ee_go || info_go || flash_go
		|| ee_rd));
	assign o_xd_hit = tgt == NVMWC_TGT_EE || tgt == NVMWC_TGT_INFO;

	always_comb begin
		o_xd_rdata = 8'h00;
		if (tgt == NVMWC_TGT_EE && !i_xd_addr[0]) begin
			o_xd_rdata = ee_rdata;
		end else if (tgt == NVMWC_TGT_INFO) begin
			o_xd_rdata = i_info_rdata;
		end
	end

	// ==========================================================
	// programming requests
	// ==========================================================
	logic [6:0] ee_idx;
	assign ee_idx = i_xd_addr[7:1];

	always_ff @(posedge i_clock or negedge rst_b_r) begin
		if (!rst_b_r) begin
			o_ee_prog_start    <= 1'b0;
			o_ee_prog_addr     <= 7'h00;
			o_ee_prog_data     <= 8'h00;
			o_ee_prog_abort    <= 1'b0;
			o_flash_prog_start <= 1'b0;
			o_flash_prog_addr  <= 16'h0000;
			o_flash_prog_data  <= 8'h00;
			o_flash_two_byte   <= 1'b0;
			o_info_prog_start  <= 1'b0;
			o_info_prog_addr   <= 6'h00;
			o_info_prog_data   <= 8'h00;
		end else begin
			o_ee_prog_start    <= state_r == NVMWC_IDLE && ee_go;
			o_flash_prog_start <= state_r == NVMWC_IDLE && !ee_go && !info_go && flash_go;
			o_info_prog_start  <= state_r == NVMWC_IDLE && !ee_go && info_go;
			o_ee_prog_abort    <= wd_expire && busy_tgt_r == NVMWC_TGT_EE;
			if (state_r == NVMWC_IDLE && i_xd_wr) begin
				o_ee_prog_addr    <= ee_idx;
				o_ee_prog_data    <= i_xd_wdata;
				o_flash_prog_addr <= i_xd_addr;
				o_flash_prog_data <= i_xd_wdata;
				o_flash_two_byte  <= two_byte_r;
				o_info_prog_addr  <= i_xd_addr[5:0];
				o_info_prog_data  <= i_xd_wdata;
			end
		end
	end

	// shadow copy serves reads; written only on a finished program
	logic ee_shadow_we;
	assign ee_shadow_we = state_r == NVMWC_PROG && busy_tgt_r == NVMWC_TGT_EE && prog_finish && !wd_expire;

	nvmwc_mem u_mem (
		.i_clock (i_clock),
		.i_we    (ee_shadow_we),
		.i_addr  (ee_shadow_we ? o_ee_prog_addr : ee_idx),
		.i_wdata (o_ee_prog_data),
		.o_rdata (ee_rdata)
	);

endmodule : nvmwc_top

/* File: tb/nvmwc_cell_model.sv */
`timescale 1ns/1ps
// ==========================================================
// nonvolatile cell macro seen from the write controller
module nvmwc_cell_model (
	input  wire logic        i_clock,
	input  wire logic        i_hang,
	input  wire logic        i_ee_start,
	input  wire logic [7:0]  i_ee_data,
	input  wire logic        i_ee_abort,
	input  wire logic        i_info_start,
	input  wire logic [5:0]  i_info_addr,
	input  wire logic [7:0]  i_info_data,
	input  wire logic [15:0] i_xd_addr,
	output logic             o_ee_done,
	output logic      [7:0]  o_info_rdata
);
	logic [7:0] info_mem [64];
	int         left;

	initial begin
		o_ee_done = 1'b0;
		left = 0;
		for (int k = 0; k < 64; k++) info_mem[k] = 8'h30 + 8'(k);
	end

	// data dependent time
	// zero bits lengthen the write; a hung cell never reports done
	always @(posedge i_clock) begin
		if (i_ee_start) begin
			o_ee_done <= 1'b0;
			left <= 8 + 2 * $countones(~i_ee_data);
		end else if (i_ee_abort) begin
			left <= 0;
		end else if (left > 0 && !i_hang) begin
			left <= left - 1;
			if (left == 1) o_ee_done <= 1'b1;
		end
	end

	always @(posedge i_clock) begin
		if (i_info_start) info_mem[i_info_addr] <= i_info_data;
	end
	assign o_info_rdata = info_mem[i_xd_addr[5:0]];
endmodule : nvmwc_cell_model

/* File: tb/nvmwc_top_asserts.sv */
`timescale 1ns/1ps
module nvmwc_top_asserts (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_sfr_wr,
	input  wire logic        i_sfr_rd,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic [7:0]  o_sfr_rdata,
	input  wire logic        i_xd_wr,
	input  wire logic        i_xd_rd,
	input  wire logic [15:0] i_xd_addr,
	input  wire logic [7:0]  o_xd_rdata,
	input  wire logic        o_xd_ready,
	input  wire logic        o_cpu_stall,
	input  wire logic        o_ee_prog_start,
	input  wire logic        o_ee_prog_abort,
	input  wire logic        i_ee_prog_done,
	input  wire logic        o_info_prog_start,
	input  wire logic [7:0]  i_info_rdata
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	logic ee_hit;
	logic info_hit;
	assign ee_hit   = i_xd_addr[15:8] == 8'hEE;
	assign info_hit = i_xd_addr[15:6] == 10'h394;
	// ==========================================================
	// command register
	sequence s_cmd;
		i_sfr_wr && i_sfr_addr == 8'hC9 && !o_cpu_stall ##1 i_sfr_rd && i_sfr_addr == 8'hC9;
	endsequence
	sequence s_stall8;
		o_cpu_stall [*8];
	endsequence
	AST_FLASH_WE: assert property (s_cmd |-> o_sfr_rdata[7] == ($past(i_sfr_wdata) inside {8'h47, 8'h74}))
		else $error("flash enable flag wrong after command");
	AST_INFO_WE: assert property (s_cmd |-> o_sfr_rdata[4] == ($past(i_sfr_wdata) == 8'hA1))
		else $error("info enable flag wrong after command");
	AST_EE_WE: assert property (s_cmd |-> o_sfr_rdata[5] == ($past(i_sfr_wdata) == 8'hE2))
		else $error("eeprom enable flag wrong after command");
	AST_TO_CLEAR: assert property (s_cmd |-> !o_sfr_rdata[6])
		else $error("timeout flag kept after command write");
	// ==========================================================
	// data space accesses
	AST_EE_ODD: assert property ($rose(i_xd_wr) && ee_hit && i_xd_addr[0] |-> o_xd_ready && !o_cpu_stall)
		else $error("odd eeprom store not refused at once");
	AST_EE_START: assert property ($rose(i_xd_wr) && ee_hit && o_cpu_stall |-> ##1 o_ee_prog_start)
		else $error("accepted eeprom store did not start programming");
	AST_EE_DONE: assert property (o_cpu_stall && $rose(i_ee_prog_done) |-> o_cpu_stall ##[2:4] o_xd_ready)
		else $error("eeprom store not finished after cell done");
	AST_EE_READ: assert property ($rose(i_xd_rd) && ee_hit && !i_xd_addr[0] |-> o_cpu_stall ##[36:38] o_xd_ready)
		else $error("eeprom load took too long");
	AST_INFO_LOAD: assert property ($rose(i_xd_rd) && info_hit |-> o_xd_ready && o_xd_rdata == i_info_rdata)
		else $error("info load waited or returned wrong byte");
	AST_INFO_STALL: assert property (o_info_prog_start |-> s_stall8 ##1 s_stall8 ##[1:8] o_xd_ready)
		else $error("info store stall length wrong");
	AST_ABORT: assert property (o_ee_prog_abort |-> ##[1:3] o_xd_ready)
		else $error("aborted write did not release the cpu");
endmodule : nvmwc_top_asserts

bind nvmwc_top nvmwc_top_asserts u_asserts (
	.i_clock(i_clock), .i_rst_b(i_rst_b), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
	.i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_xd_wr(i_xd_wr),
	.i_xd_rd(i_xd_rd), .i_xd_addr(i_xd_addr), .o_xd_rdata(o_xd_rdata), .o_xd_ready(o_xd_ready),
	.o_cpu_stall(o_cpu_stall), .o_ee_prog_start(o_ee_prog_start), .o_ee_prog_abort(o_ee_prog_abort),
	.i_ee_prog_done(i_ee_prog_done), .o_info_prog_start(o_info_prog_start), .i_info_rdata(i_info_rdata)
);

/* File: tb/nvmwc_top_bench.sv */
`timescale 1ns/1ps
module nvmwc_top_bench;
	logic             clk, rst_b, swr, srd, xwr, xrd, hang;
	logic [7:0]       sadr, swd, sq, xwd, xq;
	logic [15:0]      xadr;
	wire logic        rdy, stall, ee_st, ee_ab, ee_done, inf_st, fl_st, two;
	wire logic [7:0]  s_rd, x_rd, ee_d, inf_d, inf_rd;
	wire logic [5:0]  inf_a;
	int               fails, n_checks, cyc, n, m, fcnt;
	logic [7:0]       codes [5] = '{8'h47, 8'h74, 8'hA1, 8'hE2, 8'h00};
	logic [7:0]       flags [5] = '{8'h80, 8'h80, 8'h10, 8'h20, 8'h00};
	logic [7:0]       fl [3] = '{8'h00, 8'h47, 8'h74};

	nvmwc_top #(.WD1_CYC(40), .WD2_CYC(80), .WD3_CYC(200), .INFO_PROG_CYC(20), .FLASH_PROG_CYC(20)) i_dut (
		.i_clock(clk), .i_rst_b(rst_b), .i_sfr_wr(swr), .i_sfr_rd(srd), .i_sfr_addr(sadr),
		.i_sfr_wdata(swd), .o_sfr_rdata(s_rd), .o_sfr_hit(), .i_xd_wr(xwr), .i_xd_rd(xrd),
		.i_xd_addr(xadr), .i_xd_wdata(xwd), .o_xd_rdata(x_rd), .o_xd_hit(), .o_xd_ready(rdy),
		.o_cpu_stall(stall), .o_ee_prog_start(ee_st), .o_ee_prog_addr(), .o_ee_prog_data(ee_d),
		.o_ee_prog_abort(ee_ab), .i_ee_prog_done(ee_done), .o_flash_prog_start(fl_st),
		.o_flash_prog_addr(), .o_flash_prog_data(), .o_flash_two_byte(two), .o_info_prog_start(inf_st),
		.o_info_prog_addr(inf_a), .o_info_prog_data(inf_d), .i_info_rdata(inf_rd));

	nvmwc_cell_model u_cell (.i_clock(clk), .i_hang(hang), .i_ee_start(ee_st), .i_ee_data(ee_d),
		.i_ee_abort(ee_ab), .i_info_start(inf_st), .i_info_addr(inf_a), .i_info_data(inf_d),
		.i_xd_addr(xadr), .o_ee_done(ee_done), .o_info_rdata(inf_rd));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================================
	// tasks
	task end_sim;
		if (fails == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// optional write, then always a read of the same register next cycle
	task sfr(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1 swr = w;
		sadr = a;
		swd = d;
		if (w) begin
			@(posedge clk);
			#1 swr = 1'b0;
		end
		srd = 1'b1;
		#2 q = s_rd;
		@(posedge clk);
		#1 srd = 1'b0;
	endtask : sfr

	// request held until ready; n counts the wait cycles
	task xd(input logic w, input logic [15:0] a, input logic [7:0] d, output int k, output logic [7:0] q);
		@(posedge clk);
		#1 xwr = w;
		xrd = !w;
		xadr = a;
		xwd = d;
		k = 0;
		#1;
		while (rdy !== 1'b1 && k < 500) begin
			@(posedge clk);
			#1 k++;
		end
		q = x_rd;
		@(posedge clk);
		#1 xwr = 1'b0;
		xrd = 1'b0;
	endtask : xd

	always @(posedge clk) begin
		cyc++;
		if (fl_st === 1'b1) fcnt++;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		{swr, srd, xwr, xrd, hang, sadr, swd, xwd, xadr} = '0;
		{fails, n_checks, cyc, fcnt} = '0;
		rst_b = 1'b0;
		repeat (16) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		sfr(0, 8'hC9, 8'h00, sq);
		chk("cmd_reset", sq & 8'hF0, 8'h00);
		sfr(0, 8'hF7, 8'h00, sq);
		chk("aux_reset", sq, 8'h06);
		for (int k = 0; k < 5; k++) begin
			sfr(1, 8'hC9, codes[k], sq);
			chk("cmd_flags", sq & 8'hF0, flags[k]);
		end
		sfr(1, 8'hC9, 8'hE2, sq);
		xd(1, 16'hEE10, 8'h5A, n, xq);
		chk("ee_write_wait", 16'(n >= 16 && n <= 24), 16'h0001);
		xd(1, 16'hEE11, 8'h00, n, xq);
		chk("ee_odd_wait", 16'(n), 16'h0000);
		sfr(1, 8'hC9, 8'h00, sq);
		xd(1, 16'hEE10, 8'h00, n, xq);
		chk("ee_off_wait", 16'(n), 16'h0000);
		xd(0, 16'hEE10, 8'h00, n, xq);
		chk("ee_read", xq, 8'h5A);
		chk("ee_read_wait", 16'(n >= 36 && n <= 40), 16'h0001);
		xd(0, 16'hE505, 8'h00, n, xq);
		chk("info_read", xq, 8'h35);
		chk("info_read_wait", 16'(n), 16'h0000);
		sfr(1, 8'hC9, 8'hA1, sq);
		xd(1, 16'hE505, 8'hC3, n, xq);
		chk("info_prod_wait", 16'(n), 16'h0000);
		xd(1, 16'hE530, 8'hC3, n, xq);
		chk("info_prog_wait", 16'(n >= 20 && n <= 24), 16'h0001);
		xd(0, 16'hE505, 8'h00, n, xq);
		chk("info_prod_kept", xq, 8'h35);
		xd(0, 16'hE530, 8'h00, n, xq);
		chk("info_boot_read", xq, 8'hC3);
		for (int k = 0; k < 3; k++) begin
			sfr(1, 8'hC9, fl[k], sq);
			m = fcnt;
			xd(1, 16'h3F00, 8'h5A, n, xq);
			chk("flash_start", 16'(fcnt - m), 16'(k > 0));
			if (k > 0) chk("flash_two_byte", {15'h0000, two}, 16'(k == 2));
		end
		sfr(1, 8'hF7, 8'h02, sq);
		chk("aux_select", sq, 8'h02);
		sfr(1, 8'hC9, 8'hE2, sq);
		hang = 1'b1;
		xd(1, 16'hEE20, 8'h0F, n, xq);
		chk("wd_expiry_wait", 16'(n >= 40 && n <= 46), 16'h0001);
		sfr(0, 8'hC9, 8'h00, sq);
		chk("timeout_set", sq & 8'hF0, 8'h60);
		sfr(1, 8'hC9, 8'h00, sq);
		chk("timeout_clear", sq & 8'hF0, 8'h00);
		hang = 1'b0;
		end_sim();
	end
endmodule : nvmwc_top_bench
